// *** core/saeu_defines.vh ***
`ifndef SAEU_DEFINES_VH
`define SAEU_DEFINES_VH
// operation codes on cmdOp
`define SAEU_OP_PUSH 4'h1
`define SAEU_OP_POP 4'h2
`define SAEU_OP_LDEX 4'h3
`define SAEU_OP_STEX 4'h4
`define SAEU_OP_CLEAR 4'h5
`define SAEU_OP_BSWAP 4'h6
`define SAEU_OP_HSWAP 4'h7
`define SAEU_OP_SSWAP 4'h8
// access sizes on cmdSize / memSize
`define SAEU_SZ_BYTE 2'h0
`define SAEU_SZ_HALF 2'h1
`define SAEU_SZ_WORD 2'h2
// register numbers
`define SAEU_REG_STACK 4'hD
`define SAEU_REG_LINK 4'hE
`define SAEU_REG_PROG 4'hF
// word stride of multi-register transfers
`define SAEU_WORD_BYTES 32'h00000004
// store-exclusive status values
`define SAEU_STEX_OK 32'h00000000
`define SAEU_STEX_FAIL 32'h00000001
// reset values
`define SAEU_RST_WORD 32'h00000000
`define SAEU_RST_REG 4'h0
`endif

// *** core/saeu_regfile.v ***
`include "saeu_defines.vh"
// register bank with registered read port
module saeu_regfile #(
    parameter DW = 32,
    parameter AW = 4
) (
    input wire sys_clk,
    input wire wrEn,
    input wire [AW-1:0] wrAddr,
    input wire [DW-1:0] wrData,
    input wire [AW-1:0] rdAddr,
    output reg [DW-1:0] rdData
);
    reg [DW-1:0] mem [0:(1<<AW)-1];
    always @(posedge sys_clk)
    begin
        if (wrEn)
            mem[wrAddr] <= wrData;
        rdData <= mem[rdAddr];
    end
endmodule

// *** core/saeu_core.v ***
`include "saeu_defines.vh"
module saeu_core #(
    parameter DW = 32
) (
    input wire sys_clk,
    input wire sys_rst,
    input wire cmdValid,
    input wire [3:0] cmdOp,
    input wire [15:0] cmdRegList,
    input wire [3:0] cmdTransferReg,
    input wire [3:0] cmdBaseReg,
    input wire [3:0] cmdStatusReg,
    input wire [1:0] cmdSize,
    input wire [9:0] cmdOffset,
    input wire [DW-1:0] cmdOperand,
    input wire memReady,
    input wire [DW-1:0] memRdData,
    input wire snoopValid,
    input wire [DW-1:0] snoopAddr,
    input wire [3:0] flagsIn,
    input wire rfWrExt,
    input wire [3:0] rfWrAddrExt,
    input wire [DW-1:0] rfWrDataExt,
    output reg cmdReady,
    output reg memReq,
    output reg memWrite,
    output reg [1:0] memSize,
    output reg [DW-1:0] memAddr,
    output reg [DW-1:0] memWrData,
    output reg resValid,
    output reg [3:0] resReg,
    output reg [DW-1:0] resData,
    output reg branchValid,
    output reg [DW-1:0] branchAddr,
    output reg [3:0] flagsOut
);
    // ========================================
    // state encoding
    localparam [6:0] ST_IDLE = 7'h01;
    localparam [6:0] ST_RDREG = 7'h02;
    localparam [6:0] ST_ADDR = 7'h04;
    localparam [6:0] ST_RDDATA = 7'h08;
    localparam [6:0] ST_ACCESS = 7'h10;
    localparam [6:0] ST_WAIT = 7'h20;
    localparam [6:0] ST_DONE = 7'h40;

    reg [6:0] state_r;
    reg [3:0] op_r;
    reg [15:0] list_r;
    reg [3:0] curReg_r;
    reg [3:0] xfer_r;
    reg [3:0] rd_r;
    reg [1:0] size_r;
    reg [9:0] off_r;
    reg [DW-1:0] addr_r;
    reg [DW-1:0] stackNew_r;
    reg monOpen_r;
    reg [DW-1:0] monAddr_r;
    reg storeOk_r;
    reg [3:0] rdSel_r;
    reg rfWr;
    reg rfWrInt;
    reg [3:0] rfWrAddr;
    reg [DW-1:0] rfWrData;
    wire [DW-1:0] rfRd;

    // ========================================
    // helpers
    function [4:0] popCount;
        input [15:0] v;
        integer i;
        begin
            popCount = 5'h00;
            for (i = 0; i < 16; i = i + 1)
                popCount = popCount + {4'h0, v[i]};
        end
    endfunction

    function [3:0] lowestBit;
        input [15:0] v;
        integer i;
        begin
            lowestBit = 4'h0;
            for (i = 15; i >= 0; i = i - 1)
                if (v[i])
                    lowestBit = i[3:0];
        end
    endfunction

    function [3:0] highestBit;
        input [15:0] v;
        integer i;
        begin
            highestBit = 4'h0;
            for (i = 0; i < 16; i = i + 1)
                if (v[i])
                    highestBit = i[3:0];
        end
    endfunction

    function [DW-1:0] sizeExtend;
        input [DW-1:0] d;
        input [1:0] sz;
        begin
            case (sz)
                `SAEU_SZ_BYTE: sizeExtend = {24'h000000, d[7:0]};
                `SAEU_SZ_HALF: sizeExtend = {16'h0000, d[15:0]};
                default: sizeExtend = d;
            endcase
        end
    endfunction

    // the register bank read port is registered, so every access spends a read cycle first
    saeu_regfile #(.DW(DW), .AW(4)) uRegs (
        .sys_clk(sys_clk),
        .wrEn(rfWr),
        .wrAddr(rfWrAddr),
        .wrData(rfWrData),
        .rdAddr(rdSel_r),
        .rdData(rfRd)
    );

    wire isPush = (op_r == `SAEU_OP_PUSH);
    wire isPop = (op_r == `SAEU_OP_POP);
    wire isLdex = (op_r == `SAEU_OP_LDEX);
    wire isStex = (op_r == `SAEU_OP_STEX);
    // store-exclusive only proceeds while the monitor is open on the same address
    // a snoop hitting in the same cycle must fail the store as well
    wire snoopHit = snoopValid && (snoopAddr == monAddr_r);
    wire stexPass = monOpen_r && (monAddr_r == addr_r) && !snoopHit;
    wire [3:0] nextReg = isPush ? highestBit(list_r) : lowestBit(list_r);
    wire [15:0] listLeft = list_r & ~(16'h0001 << curReg_r);

    // ========================================
    // bank write port: completed loads except into the program counter, stack pointer update, exclusive status, else external writeback
    always @*
    begin
        rfWr = rfWrExt;
        rfWrInt = 1'b0;
        rfWrAddr = rfWrAddrExt;
        rfWrData = rfWrDataExt;
        if (state_r == ST_WAIT && memReady && !memWrite && curReg_r != `SAEU_REG_PROG)
        begin
            rfWr = 1'b1;
            rfWrInt = 1'b1;
            rfWrAddr = curReg_r;
            rfWrData = sizeExtend(memRdData, size_r);
        end
        else if (state_r == ST_DONE && (isPush || isPop))
        begin
            rfWr = 1'b1;
            rfWrInt = 1'b1;
            rfWrAddr = `SAEU_REG_STACK;
            rfWrData = stackNew_r;
        end
        else if (state_r == ST_DONE && isStex)
        begin
            rfWr = 1'b1;
            rfWrInt = 1'b1;
            rfWrAddr = rd_r;
            rfWrData = storeOk_r ? `SAEU_STEX_OK : `SAEU_STEX_FAIL;
        end
    end

    // ========================================
    // sequencer
    always @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_r <= ST_IDLE;
            op_r <= 4'h0;
            list_r <= 16'h0000;
            curReg_r <= `SAEU_RST_REG;
            xfer_r <= `SAEU_RST_REG;
            rd_r <= `SAEU_RST_REG;
            size_r <= `SAEU_SZ_WORD;
            off_r <= 10'h000;
            addr_r <= `SAEU_RST_WORD;
            stackNew_r <= `SAEU_RST_WORD;
            monOpen_r <= 1'b0;
            monAddr_r <= `SAEU_RST_WORD;
            storeOk_r <= 1'b0;
            rdSel_r <= `SAEU_RST_REG;
            cmdReady <= 1'b1;
            memReq <= 1'b0;
            memWrite <= 1'b0;
            memSize <= `SAEU_SZ_WORD;
            memAddr <= `SAEU_RST_WORD;
            memWrData <= `SAEU_RST_WORD;
            resValid <= 1'b0;
            resReg <= `SAEU_RST_REG;
            resData <= `SAEU_RST_WORD;
            branchValid <= 1'b0;
            branchAddr <= `SAEU_RST_WORD;
            flagsOut <= 4'h0;
        end
        else
        begin
            resValid <= 1'b0;
            branchValid <= 1'b0;
            flagsOut <= flagsIn;
            // every internal bank write is echoed on the result port
            if (rfWrInt)
            begin
                resValid <= 1'b1;
                resReg <= rfWrAddr;
                resData <= rfWrData;
            end
            // another master touching the tagged location breaks the reservation
            if (snoopValid && snoopAddr == monAddr_r)
                monOpen_r <= 1'b0;
            case (state_r)
                ST_IDLE:
                begin
                    if (cmdValid)
                    begin
                        op_r <= cmdOp;
                        list_r <= cmdRegList;
                        xfer_r <= cmdTransferReg;
                        off_r <= cmdOffset;
                        rd_r <= cmdStatusReg;
                        size_r <= (cmdOp == `SAEU_OP_PUSH || cmdOp == `SAEU_OP_POP) ?
                            `SAEU_SZ_WORD : cmdSize;
                        case (cmdOp)
                            `SAEU_OP_CLEAR:
                                monOpen_r <= 1'b0;
                            `SAEU_OP_BSWAP:
                            begin
                                resValid <= 1'b1;
                                resReg <= cmdTransferReg;
                                resData <= {cmdOperand[7:0], cmdOperand[15:8],
                                    cmdOperand[23:16], cmdOperand[31:24]};
                            end
                            `SAEU_OP_HSWAP:
                            begin
                                resValid <= 1'b1;
                                resReg <= cmdTransferReg;
                                resData <= {cmdOperand[23:16], cmdOperand[31:24],
                                    cmdOperand[7:0], cmdOperand[15:8]};
                            end
                            `SAEU_OP_SSWAP:
                            begin
                                resValid <= 1'b1;
                                resReg <= cmdTransferReg;
                                resData <= {{16{cmdOperand[7]}}, cmdOperand[7:0],
                                    cmdOperand[15:8]};
                            end
                            `SAEU_OP_PUSH, `SAEU_OP_POP, `SAEU_OP_LDEX, `SAEU_OP_STEX:
                            begin
                                cmdReady <= 1'b0;
                                rdSel_r <= (cmdOp == `SAEU_OP_PUSH || cmdOp == `SAEU_OP_POP) ?
                                    `SAEU_REG_STACK : cmdBaseReg;
                                state_r <= ST_RDREG;
                            end
                            default:
                                state_r <= ST_IDLE;
                        endcase
                    end
                end
                // the bank read lags rdSel_r by one edge, so each read gets a settle cycle
                ST_RDREG:
                    state_r <= ST_ADDR;
                ST_ADDR:
                begin
                    // rfRd holds the base (stack pointer or base register) here
                    if (isPush)
                    begin
                        addr_r <= rfRd - {popCount(list_r), 2'b00};
                        stackNew_r <= rfRd - {popCount(list_r), 2'b00};
                    end
                    else if (isPop)
                    begin
                        addr_r <= rfRd;
                        stackNew_r <= rfRd + {popCount(list_r), 2'b00};
                    end
                    else
                        addr_r <= rfRd + {22'h000000, off_r};
                    if (isStex)
                        rdSel_r <= xfer_r;
                    else
                        rdSel_r <= nextReg;
                    state_r <= ST_RDDATA;
                end
                ST_RDDATA:
                    state_r <= ST_ACCESS;
                ST_ACCESS:
                begin
                    memSize <= size_r;
                    memAddr <= addr_r;
                    memWrData <= rfRd;
                    if (isPush)
                    begin
                        // push fills from the top down; start address is the top word
                        curReg_r <= nextReg;
                        memAddr <= addr_r + {popCount(list_r) - 5'h01, 2'b00};
                        memWrite <= 1'b1;
                        memReq <= 1'b1;
                        state_r <= ST_WAIT;
                    end
                    else if (isPop)
                    begin
                        curReg_r <= nextReg;
                        // lowest remaining register takes the lowest remaining word
                        memAddr <= stackNew_r - {popCount(list_r), 2'b00};
                        memWrite <= 1'b0;
                        memReq <= 1'b1;
                        state_r <= ST_WAIT;
                    end
                    else if (isLdex)
                    begin
                        curReg_r <= xfer_r;
                        monOpen_r <= 1'b1;
                        monAddr_r <= addr_r;
                        memWrite <= 1'b0;
                        memReq <= 1'b1;
                        state_r <= ST_WAIT;
                    end
                    else
                    begin
                        storeOk_r <= stexPass;
                        monOpen_r <= 1'b0;
                        memWrite <= 1'b1;
                        memReq <= stexPass;
                        state_r <= stexPass ? ST_WAIT : ST_DONE;
                    end
                end
                ST_WAIT:
                begin
                    if (memReady)
                    begin
                        memReq <= 1'b0;
                        if (!memWrite && curReg_r == `SAEU_REG_PROG)
                        begin
                            branchValid <= 1'b1;
                            branchAddr <= {memRdData[DW-1:1], 1'b0};
                        end
                        list_r[curReg_r] <= 1'b0;
                        if ((isPush || isPop) && popCount(list_r) > 5'h01)
                        begin
                            rdSel_r <= isPush ? highestBit(listLeft) : lowestBit(listLeft);
                            state_r <= ST_RDDATA;
                        end
                        else
                            state_r <= ST_DONE;
                    end
                end
                ST_DONE:
                begin
                    cmdReady <= 1'b1;
                    state_r <= ST_IDLE;
                end
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end
endmodule

// *** verification/saeu_monitor.sv ***
`include "saeu_defines.vh"
module saeu_monitor #(
    parameter DW = 32
) (
    input logic sys_clk,
    input logic sys_rst,
    input logic cmdValid,
    input logic cmdReady,
    input logic [3:0] cmdOp,
    input logic [1:0] cmdSize,
    input logic snoopValid,
    input logic memReq,
    input logic memReady,
    input logic memWrite,
    input logic [1:0] memSize,
    input logic [DW-1:0] memAddr,
    input logic resValid,
    input logic [DW-1:0] resData,
    input logic branchValid,
    input logic [DW-1:0] branchAddr,
    input logic [3:0] flagsIn,
    input logic [3:0] flagsOut
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] lastOp_r;
    logic [1:0] lastSize_r;
    logic [1:0] upCnt_r;
    logic open_r;
    logic armed_r;
    logic seen_r;
    logic [DW-1:0] prev_r;
    // ========================================
    // operation tracking
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            lastOp_r <= 4'h0;
            lastSize_r <= 2'h0;
            upCnt_r <= 2'h0;
            open_r <= 1'b0;
            armed_r <= 1'b0;
            seen_r <= 1'b0;
            prev_r <= '0;
        end
        else
        begin
            if (upCnt_r != 2'h3)
                upCnt_r <= upCnt_r + 2'h1;
            // any snoop closes: the bench only snoops the tagged address
            if (snoopValid)
                open_r <= 1'b0;
            if (cmdValid && cmdReady)
            begin
                lastOp_r <= cmdOp;
                lastSize_r <= cmdSize;
                seen_r <= 1'b0;
                armed_r <= open_r && !snoopValid;
                if (cmdOp == `SAEU_OP_LDEX)
                    open_r <= 1'b1;
                else if (cmdOp == `SAEU_OP_STEX || cmdOp == `SAEU_OP_CLEAR)
                    open_r <= 1'b0;
            end
            else if (memReq && memReady)
            begin
                seen_r <= 1'b1;
                prev_r <= memAddr;
            end
        end
    end
    // ========================================
    // properties
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);
    AST_FLAGS_KEPT: assert property (
        upCnt_r == 2'h3 && $stable(flagsIn) |-> flagsOut == flagsIn)
        else $error("flags altered");
    AST_REQ_HOLD: assert property (
        memReq && !memReady |=> memReq && $stable(memAddr) && $stable(memWrite))
        else $error("memory request dropped or changed");
    AST_PUSH_WR: assert property (
        memReq && lastOp_r == `SAEU_OP_PUSH |-> memWrite && memSize == `SAEU_SZ_WORD)
        else $error("stack store not a word write");
    AST_PUSH_STEP: assert property (
        memReq && memReady && seen_r && lastOp_r == `SAEU_OP_PUSH
        |-> memAddr == prev_r - `SAEU_WORD_BYTES)
        else $error("stack store address step wrong");
    AST_POP_STEP: assert property (
        memReq && memReady && seen_r && lastOp_r == `SAEU_OP_POP
        |-> !memWrite && memAddr == prev_r + `SAEU_WORD_BYTES)
        else $error("stack load address step wrong");
    AST_BRANCH_HALF: assert property (
        branchValid |-> branchAddr[0] == 1'b0)
        else $error("branch target odd");
    AST_LDEX_SIZE: assert property (
        memReq && lastOp_r == `SAEU_OP_LDEX |-> !memWrite && memSize == lastSize_r)
        else $error("exclusive load access wrong");
    AST_STEX_GATED: assert property (
        memReq && lastOp_r == `SAEU_OP_STEX |-> memWrite && armed_r && memSize == lastSize_r)
        else $error("exclusive store without open monitor");
    AST_STEX_STATUS: assert property (
        resValid && lastOp_r == `SAEU_OP_STEX |-> resData == (armed_r ? 32'h0 : 32'h1))
        else $error("exclusive store status wrong");
    AST_REV_NO_MEM: assert property (
        memReq |-> lastOp_r inside {`SAEU_OP_PUSH, `SAEU_OP_POP, `SAEU_OP_LDEX, `SAEU_OP_STEX})
        else $error("memory access from a non-memory operation");
endmodule

// *** verification/saeu_mem_model.sv ***
module saeu_mem_model #(
    parameter DW = 32,
    parameter WORDS = 128
) (
    input logic sys_clk,
    input logic sys_rst,
    input logic [3:0] waitCycles,
    input logic memReq,
    input logic memWrite,
    input logic [DW-1:0] memAddr,
    input logic [DW-1:0] memWrData,
    output logic memReady,
    output logic [DW-1:0] memRdData
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [DW-1:0] store [WORDS];
    logic [3:0] waitCnt_r;
    // ========================================
    // word memory, lanes ignored: narrow data sits in the low bits
    always @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            memReady <= 1'b0;
            memRdData <= 32'hA5A5A5A5;
            waitCnt_r <= 4'h0;
            for (int i = 0; i < WORDS; i++)
                store[i] <= 32'h5A000000 | 32'(i * 4);
        end
        else if (memReady)
            memReady <= 1'b0;
        else if (memReq && waitCnt_r >= waitCycles)
        begin
            memReady <= 1'b1;
            waitCnt_r <= 4'h0;
            if (memWrite)
                store[memAddr[8:2]] <= memWrData;
            else
                memRdData <= store[memAddr[8:2]];
        end
        else
        begin
            // stale read data never looks valid
            memRdData <= ~memRdData;
            if (memReq)
                waitCnt_r <= waitCnt_r + 4'h1;
        end
    end
endmodule

// *** verification/saeu_core_bench.sv ***
`include "saeu_defines.vh"
module saeu_core_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [1:0] W = `SAEU_SZ_WORD;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic cmdValid = 1'b0, rfWrExt = 1'b0, snoopValid = 1'b0;
    logic [3:0] cmdOp = 4'h0, cmdTransferReg = 4'h0, cmdBaseReg = 4'h0, cmdStatusReg = 4'h0;
    logic [3:0] rfWrAddrExt = 4'h0, flagsIn = 4'hA, memWait = 4'h0;
    logic [15:0] cmdRegList = 16'h0000;
    logic [1:0] cmdSize = 2'h0;
    logic [9:0] cmdOffset = 10'h000;
    logic [31:0] cmdOperand = 32'h0, snoopAddr = 32'h0, rfWrDataExt = 32'h0;
    logic cmdReady, memReq, memWrite, memReady, resValid, branchValid;
    logic [1:0] memSize;
    logic [3:0] resReg, flagsOut;
    logic [31:0] memAddr, memWrData, memRdData, resData, branchAddr, lastBranch;
    logic [31:0] accAddrQ[$], accDataQ[$], resDataQ[$];
    logic [3:0] resRegQ[$];
    logic accWrQ[$];
    int miscompares = 0;
    int compares = 0;
    saeu_core #(.DW(32)) dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .cmdValid(cmdValid), .cmdOp(cmdOp),
        .cmdRegList(cmdRegList), .cmdTransferReg(cmdTransferReg), .cmdBaseReg(cmdBaseReg),
        .cmdStatusReg(cmdStatusReg), .cmdSize(cmdSize), .cmdOffset(cmdOffset),
        .cmdOperand(cmdOperand), .memReady(memReady), .memRdData(memRdData),
        .snoopValid(snoopValid), .snoopAddr(snoopAddr), .flagsIn(flagsIn),
        .rfWrExt(rfWrExt), .rfWrAddrExt(rfWrAddrExt), .rfWrDataExt(rfWrDataExt),
        .cmdReady(cmdReady), .memReq(memReq), .memWrite(memWrite), .memSize(memSize),
        .memAddr(memAddr), .memWrData(memWrData), .resValid(resValid), .resReg(resReg),
        .resData(resData), .branchValid(branchValid), .branchAddr(branchAddr),
        .flagsOut(flagsOut));
    saeu_mem_model mem (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .waitCycles(memWait), .memReq(memReq),
        .memWrite(memWrite), .memAddr(memAddr), .memWrData(memWrData),
        .memReady(memReady), .memRdData(memRdData));
    initial
    begin
        forever #20 sys_clk = ~sys_clk;
    end
    // ========================================
    // observation
    always @(posedge sys_clk)
    begin
        if (memReq && memReady)
        begin
            accAddrQ.push_back(memAddr);
            accDataQ.push_back(memWrData);
            accWrQ.push_back(memWrite);
        end
        if (resValid)
        begin
            resRegQ.push_back(resReg);
            resDataQ.push_back(resData);
        end
        if (branchValid)
            lastBranch = branchAddr;
    end
    // ========================================
    // shared tasks
    task automatic end_sim;
        if (miscompares == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] res_of(input logic [3:0] r);
        logic [31:0] v;
        v = 'x;
        foreach (resRegQ[i])
            if (resRegQ[i] === r)
                v = resDataQ[i];
        return v;
    endfunction
    task automatic rfw(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        rfWrExt <= 1'b1;
        rfWrAddrExt <= a;
        rfWrDataExt <= d;
        @(posedge sys_clk);
        rfWrExt <= 1'b0;
    endtask
    // holds the request until taken, then waits for the unit to go idle
    task automatic issue(input logic [3:0] op, input logic [15:0] list, input logic [3:0] t,
                         input logic [3:0] s, input logic [1:0] sz, input logic [31:0] opnd);
        logic ok;
        accAddrQ.delete();
        accDataQ.delete();
        accWrQ.delete();
        resRegQ.delete();
        resDataQ.delete();
        @(posedge sys_clk);
        cmdValid <= 1'b1;
        cmdOp <= op;
        cmdRegList <= list;
        cmdTransferReg <= t;
        cmdBaseReg <= 4'h6;
        cmdStatusReg <= s;
        cmdSize <= sz;
        cmdOperand <= opnd;
        ok = 1'b0;
        for (int i = 0; i < 100 && !ok; i++)
        begin
            @(negedge sys_clk);
            ok = cmdReady;
            @(posedge sys_clk);
        end
        cmdValid <= 1'b0;
        chk(32'(ok), 32'h1);
        repeat (2) @(negedge sys_clk);
        for (int i = 0; i < 200 && !(cmdReady && !memReq); i++)
            @(negedge sys_clk);
        repeat (3) @(posedge sys_clk);
    endtask
    // ========================================
    // scenarios
    task automatic t_stack;
        rfw(`SAEU_REG_STACK, 32'h100);
        rfw(4'h1, 32'h11111111);
        rfw(4'h2, 32'h22222222);
        issue(`SAEU_OP_PUSH, 16'h0006, 4'h0, 4'h0, W, 32'h0);
        chk(accAddrQ[0], 32'hFC);
        chk(accDataQ[0], 32'h22222222);
        chk(accAddrQ[1], 32'hF8);
        chk(accDataQ[1], 32'h11111111);
        chk(32'(accAddrQ.size()), 32'h2);
        chk(res_of(`SAEU_REG_STACK), 32'hF8);
        memWait <= 4'h3;
        issue(`SAEU_OP_POP, 16'h0018, 4'h0, 4'h0, W, 32'h0);
        chk(accAddrQ[0], 32'hF8);
        chk(res_of(4'h3), 32'h11111111);
        chk(res_of(4'h4), 32'h22222222);
        memWait <= 4'h0;
    endtask
    task automatic t_branch;
        rfw(`SAEU_REG_STACK, 32'h100);
        rfw(4'h5, 32'h201);
        lastBranch = 'x;
        issue(`SAEU_OP_PUSH, 16'h0020, 4'h0, 4'h0, W, 32'h0);
        issue(`SAEU_OP_POP, 16'h8000, 4'h0, 4'h0, W, 32'h0);
        chk(lastBranch, 32'h200);
    endtask
    task automatic t_excl;
        logic [1:0] sz;
        logic [31:0] exp;
        rfw(4'h6, 32'h40);
        for (int k = 2; k >= 0; k--)
        begin
            sz = 2'(k);
            exp = (k == 2) ? 32'h5A000040 : 32'h40;
            memWait <= 4'(k);
            issue(`SAEU_OP_LDEX, 16'h0, 4'h7, 4'h0, sz, 32'h0);
            chk(res_of(4'h7), exp);
            chk(accAddrQ[0], 32'h40);
            issue(`SAEU_OP_STEX, 16'h0, 4'h7, 4'h8, sz, 32'h0);
            chk(res_of(4'h8), 32'h0);
            chk(32'(accWrQ[0]), 32'h1);
            issue(`SAEU_OP_CLEAR, 16'h0, 4'h0, 4'h0, sz, 32'h0);
            issue(`SAEU_OP_STEX, 16'h0, 4'h7, 4'h8, sz, 32'h0);
            chk(res_of(4'h8), 32'h1);
            chk(32'(accAddrQ.size()), 32'h0);
            issue(`SAEU_OP_LDEX, 16'h0, 4'h7, 4'h0, sz, 32'h0);
            @(posedge sys_clk);
            snoopValid <= 1'b1;
            snoopAddr <= 32'h40;
            @(posedge sys_clk);
            snoopValid <= 1'b0;
            issue(`SAEU_OP_STEX, 16'h0, 4'h7, 4'h8, sz, 32'h0);
            chk(res_of(4'h8), 32'h1);
        end
        cmdOffset <= 10'h008;
        issue(`SAEU_OP_LDEX, 16'h0, 4'h7, 4'h0, W, 32'h0);
        chk(accAddrQ[0], 32'h48);
        chk(res_of(4'h7), 32'h5A000048);
        cmdOffset <= 10'h000;
    endtask
    task automatic t_rev;
        issue(`SAEU_OP_BSWAP, 16'h0, 4'h9, 4'h0, W, 32'h12345680);
        chk(resDataQ[0], 32'h80563412);
        issue(`SAEU_OP_HSWAP, 16'h0, 4'h9, 4'h0, W, 32'h12345680);
        chk(resDataQ[0], 32'h34128056);
        issue(`SAEU_OP_SSWAP, 16'h0, 4'h9, 4'h0, W, 32'h12345680);
        chk(resDataQ[0], 32'hFFFF8056);
        chk(32'(flagsOut), 32'hA);
    endtask
    initial
    begin
        repeat (12) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_stack();
        t_branch();
        t_excl();
        t_rev();
        end_sim();
    end
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        miscompares++;
        end_sim();
    end
endmodule
bind saeu_core saeu_monitor #(.DW(DW)) mon (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .cmdValid(cmdValid), .cmdReady(cmdReady),
    .cmdOp(cmdOp), .cmdSize(cmdSize), .snoopValid(snoopValid), .memReq(memReq),
    .memReady(memReady), .memWrite(memWrite), .memSize(memSize), .memAddr(memAddr),
    .resValid(resValid), .resData(resData), .branchValid(branchValid),
    .branchAddr(branchAddr), .flagsIn(flagsIn), .flagsOut(flagsOut));
